// ### rtl/bss_rx_sync.sv
// Purpose: per-channel receive sync machines and character status for bonded channels
// Assumes: one decoded character per clock per channel, flags from the decoder
// Notes:
// Notes on behaviour
// (RQ1) one sync machine per channel, bonding enabled
// (RQ2) machine tracks framing loss and bonding recovery
// (RQ3) bonding off: no machine, decoder status
// (RQ4) Type A and Type B machine forms
// (RQ5) Type A: four states, in_sync multi-code
// (RQ6) Type B: four states, mixed code counts
// (RQ7) 000 prio 7: valid data character
// (RQ8) 001 prio 7: valid non-framing special
// (RQ9) Type A 010 prio 2: buffer error; in resync the code reports 111 instead
// (RQ10) Type B 010: lock, last framing before data
// (RQ11) 011 prio 5: framing character, decoded value
// (RQ12) 100 prio 4: undecodable, output C0.7
// (RQ13) 101 prio 1: sync lost or misaligned
// (RQ14) 110 prio 6: disparity error, C4.7/C1.7/C2.7; the code ranks 110 above 011 (prio 5)
// (RQ15) 111 prio 3: resync, output framing character
// (RQ16) lowest priority number wins
// (RQ17) mode bit 0 selects Type A/B
// (RQ18) transitions set by parameters
`timescale 1ns/1ps
`include "bss_defs.svh"
module bss_rx_sync #(
  parameter int NCH = 4,
  parameter int ERR_LIMIT = `BSS_ERR_LIMIT,
  parameter int BOND_WIN = `BSS_BOND_WIN
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_arst_n,
  // register port
  input wire logic [7:0] i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [31:0] o_reg_rdata,
  // decoded characters from the receive path
  input wire logic [NCH-1:0][7:0] i_dec_char,
  input wire logic [NCH-1:0] i_is_framing,
  input wire logic [NCH-1:0] i_is_special,
  input wire logic [NCH-1:0] i_code_viol,
  input wire logic [NCH-1:0] i_disp_err,
  input wire logic [NCH-1:0] i_ebuf_err,
  input wire logic [NCH-1:0] i_pll_unlock,
  // parallel output to host logic
  output logic [NCH-1:0][7:0] o_rx_data,
  output logic [NCH-1:0][2:0] o_rx_char_status
);
  import bss_pkg::*;

  localparam int WINW = $clog2(BOND_WIN + 2);
  localparam logic [WINW-1:0] WIN_LAST = WINW'(BOND_WIN);
  localparam int ERRW = $clog2(ERR_LIMIT + 1);
  localparam logic [ERRW-1:0] ERR_LAST = ERRW'(ERR_LIMIT - 1);

  // ----------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
    hit = (addr == ofs);
  endfunction

  // framing character that decoded cleanly
  function automatic logic clean_frame(input logic framing, input logic err);
    clean_frame = framing && !err;
  endfunction

  logic [1:0] rx_mode_select;
  logic resync_req;
  logic [15:0] lock_count;
  logic chan_lock;
  logic win_expired;
  logic lock_event;
  logic type_b;
  logic bonded;
  bss_state_t [NCH-1:0] st_vec;
  logic ctrl_wr;
  logic cnt_wr;

  assign ctrl_wr = i_reg_wr && hit(i_reg_addr, `BSS_OFS_CTRL);
  assign cnt_wr = i_reg_wr && hit(i_reg_addr, `BSS_OFS_LOCKCNT);
  assign type_b = rx_mode_select[`BSS_CTRL_TYPEB_BIT]; // RQ17 RQ4
  assign bonded = rx_mode_select[`BSS_CTRL_BOND_BIT]; // RQ1 RQ3

  always_ff @(posedge i_core_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      rx_mode_select <= `BSS_MODE_RST;
    else if (ctrl_wr)
      rx_mode_select <= i_reg_wdata[1:0];
  end

  // write-one pulse forcing every machine back to no_sync
  always_ff @(posedge i_core_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      resync_req <= 1'b0;
    else
      resync_req <= ctrl_wr && i_reg_wdata[`BSS_CTRL_RESYNC_BIT];
  end

  // counts bonded lock-ups; a write clears it, an event in that cycle is counted after the clear
  always_ff @(posedge i_core_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      lock_count <= 16'h0000;
    else if (lock_event)
      lock_count <= cnt_wr ? 16'h0001 : lock_count + 16'h0001;
    else if (cnt_wr)
      lock_count <= 16'h0000;
  end

  // ----------------------------------------------------------------
  // read path: data in the cycle after the strobe only
  // ----------------------------------------------------------------
  logic [31:0] next_rdata;
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    if (hit(i_reg_addr, `BSS_OFS_CTRL))
      next_rdata[1:0] = rx_mode_select;
    else if (hit(i_reg_addr, `BSS_OFS_STAT))
    begin
      for (int c = 0; c < NCH; c++)
        next_rdata[2*c +: 2] = st_vec[c];
      next_rdata[`BSS_STAT_LOCK_BIT] = chan_lock;
      next_rdata[`BSS_STAT_WINEXP_BIT] = win_expired;
    end
    else if (hit(i_reg_addr, `BSS_OFS_LOCKCNT))
      next_rdata[15:0] = lock_count;
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      o_reg_rdata <= 32'h0000_0000;
    else
      o_reg_rdata <= i_reg_rd ? next_rdata : 32'h0000_0000;
  end

  // ----------------------------------------------------------------
  // bonding window shared by all channels
  // ----------------------------------------------------------------
  logic any_resync;
  logic all_ready;
  logic [WINW-1:0] win_cnt;
  always_comb
  begin
    any_resync = 1'b0;
    all_ready = 1'b1;
    for (int c = 0; c < NCH; c++)
    begin
      any_resync = any_resync | (st_vec[c] == st_resync);
      all_ready = all_ready & ((st_vec[c] == st_resync) || (st_vec[c] == st_in_sync));
    end
  end

  // window opens when the first channel enters resync
  always_ff @(posedge i_core_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      win_cnt <= '0;
    else if (!any_resync)
      win_cnt <= '0;
    else if (!win_expired)
      win_cnt <= win_cnt + WINW'(1);
  end

  assign win_expired = (win_cnt > WIN_LAST);
  assign chan_lock = bonded && all_ready && !win_expired; // RQ2 RQ18

  // ----------------------------------------------------------------
  // per-channel machines, staging and status
  // ----------------------------------------------------------------
  logic [NCH-1:0] lock_hit;
  assign lock_event = |lock_hit;

  for (genvar c = 0; c < NCH; c++)
  begin : g_ch
    bss_state_t st;
    bss_state_t next_st;
    logic dec_err;
    logic [ERRW-1:0] err_bal;
    logic [7:0] stg_char;
    logic [7:0] last_frame;
    logic stg_framing;
    logic stg_special;
    logic stg_viol;
    logic stg_disp;
    logic stg_ebuf;
    logic stg_pll;
    bss_state_t stg_st;
    bss_state_t next_stg_st;
    bss_enc_if e ();

    assign dec_err = i_code_viol[c] | i_disp_err[c];
    assign st_vec[c] = st;

    always_comb
    begin
      next_st = st;
      if (!bonded || resync_req || i_pll_unlock[c] || (type_b && i_ebuf_err[c]))
        next_st = st_no_sync; // RQ3 RQ4 RQ18
      else
      begin
        case (st)
          st_no_sync:
            if (clean_frame(i_is_framing[c], dec_err))
              next_st = st_resync; // RQ2 RQ18
          st_resync:
            if (dec_err)
              next_st = st_no_sync; // RQ18
            else if (!i_is_framing[c])
              next_st = chan_lock ? st_in_sync : st_bond_failed; // RQ2 RQ18
          st_in_sync:
            if (dec_err && err_bal == ERR_LAST)
              next_st = st_no_sync; // RQ2 RQ18
          st_bond_failed:
            if (clean_frame(i_is_framing[c], dec_err))
              next_st = st_resync; // RQ18
          default:
            next_st = st_no_sync;
        endcase
      end
    end

    always_ff @(posedge i_core_clk or negedge i_arst_n)
    begin
      if (!i_arst_n)
        st <= st_no_sync;
      else
        st <= next_st; // RQ1 RQ5 RQ6
    end

    // invalid-minus-valid balance while in sync, floored at zero
    always_ff @(posedge i_core_clk or negedge i_arst_n)
    begin
      if (!i_arst_n)
        err_bal <= '0;
      else if (st != st_in_sync || next_st != st_in_sync)
        err_bal <= '0;
      else if (dec_err)
        err_bal <= err_bal + ERRW'(1);
      else if (err_bal != '0)
        err_bal <= err_bal - ERRW'(1);
    end

    assign lock_hit[c] = (st == st_resync) && (next_st == st_in_sync);

    // a character that ends resync is reported from the state it leads
    // into, so the aligned data after the lock mark carries its own status
    always_comb
    begin
      next_stg_st = st;
      if (st == st_resync && next_st != st_resync)
        next_stg_st = next_st; // RQ10 RQ15
    end

    // one stage so a framing character can be tagged by what follows it
    always_ff @(posedge i_core_clk or negedge i_arst_n)
    begin
      if (!i_arst_n)
        stg_char <= 8'h00;
      else
        stg_char <= i_dec_char[c];
    end

    // decoder flags staged beside their character
    always_ff @(posedge i_core_clk or negedge i_arst_n)
    begin
      if (!i_arst_n)
      begin
        stg_framing <= 1'b0;
        stg_special <= 1'b0;
        stg_viol <= 1'b0;
        stg_disp <= 1'b0;
        stg_ebuf <= 1'b0;
        stg_pll <= 1'b0;
      end
      else
      begin
        stg_framing <= i_is_framing[c];
        stg_special <= i_is_special[c];
        stg_viol <= i_code_viol[c];
        stg_disp <= i_disp_err[c];
        stg_ebuf <= i_ebuf_err[c];
        stg_pll <= i_pll_unlock[c];
      end
    end

    // state the staged character is reported from
    always_ff @(posedge i_core_clk or negedge i_arst_n)
    begin
      if (!i_arst_n)
        stg_st <= st_no_sync;
      else
        stg_st <= next_stg_st; // RQ5 RQ6 RQ10
    end

    // most recent cleanly decoded framing character
    always_ff @(posedge i_core_clk or negedge i_arst_n)
    begin
      if (!i_arst_n)
        last_frame <= 8'h00;
      else if (clean_frame(i_is_framing[c], dec_err))
        last_frame <= i_dec_char[c]; // RQ15
    end

    // ----------------------------------------------------------------
    // status encoding and output register
    // ----------------------------------------------------------------
    assign e.ch = stg_char;
    assign e.last_frame = last_frame;
    assign e.is_framing = stg_framing;
    assign e.is_special = stg_special;
    assign e.code_viol = stg_viol;
    assign e.disp_err = stg_disp;
    assign e.ebuf_err = stg_ebuf;
    assign e.pll_unlock = stg_pll;
    assign e.type_b = type_b;
    assign e.bonded = bonded;
    assign e.state = stg_st;
    // staged framing char is the last one before aligned data
    assign e.lock_mark = type_b && stg_framing && lock_hit[c]; // RQ10

    bss_status_enc u_enc (
      .e(e.enc)
    );

    always_ff @(posedge i_core_clk or negedge i_arst_n)
    begin
      if (!i_arst_n)
      begin
        o_rx_data[c] <= 8'h00;
        o_rx_char_status[c] <= `BSS_ST_LOSS;
      end
      else
      begin
        o_rx_data[c] <= e.char_out; // RQ11 RQ12 RQ14 RQ15
        o_rx_char_status[c] <= e.code; // RQ7 RQ8 RQ9 RQ13 RQ16
      end
    end
  end
endmodule // bss_rx_sync

// ### include/bss_defs.svh
// Purpose: constants of the bonded receive sync/status block
// Assumes: 32-bit register port, byte addresses
// Notes:   status codes, substitute characters and register layout
`ifndef BSS_DEFS_SVH
`define BSS_DEFS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define BSS_OFS_CTRL 8'h00
`define BSS_OFS_STAT 8'h04
`define BSS_OFS_LOCKCNT 8'h08

// ----------------------------------------------------------------
// control fields and reset values
// ----------------------------------------------------------------
`define BSS_CTRL_TYPEB_BIT 0
`define BSS_CTRL_BOND_BIT 1
`define BSS_CTRL_RESYNC_BIT 2
`define BSS_MODE_RST 2'h2
`define BSS_STAT_LOCK_BIT 16
`define BSS_STAT_WINEXP_BIT 17

// ----------------------------------------------------------------
// status codes
// ----------------------------------------------------------------
`define BSS_ST_DATA 3'h0
`define BSS_ST_SPECIAL 3'h1
`define BSS_ST_EBUF_LOCK 3'h2
`define BSS_ST_FRAME 3'h3
`define BSS_ST_VIOL 3'h4
`define BSS_ST_LOSS 3'h5
`define BSS_ST_DISP 3'h6
`define BSS_ST_RESYNC 3'h7

// ----------------------------------------------------------------
// substitute characters and timing counts
// ----------------------------------------------------------------
`define BSS_CHAR_C07 8'he0
`define BSS_CHAR_C17 8'he1
`define BSS_CHAR_C27 8'he2
`define BSS_CHAR_C47 8'he4
`define BSS_ERR_LIMIT 4
`define BSS_BOND_WIN 16

`endif

// ### include/bss_pkg.sv
// Purpose: types of the bonded receive sync/status block
// Assumes: nothing
// Notes:   gray codes along no_sync -> resync -> in_sync
package bss_pkg;

  typedef enum logic [1:0] {
    st_no_sync = 2'h0,
    st_resync = 2'h1,
    st_in_sync = 2'h3,
    st_bond_failed = 2'h2
  } bss_state_t;

endpackage

// ### include/bss_enc_if.sv
// Purpose: carries one channel's staged character to the status encoder
// Assumes: one character per clock
// Notes:   ctl side drives flags, enc side returns code and character
`timescale 1ns/1ps
interface bss_enc_if;
  import bss_pkg::*;
  logic [7:0] ch;
  logic [7:0] last_frame;
  logic is_framing;
  logic is_special;
  logic code_viol;
  logic disp_err;
  logic ebuf_err;
  logic pll_unlock;
  logic type_b;
  logic bonded;
  logic lock_mark;
  bss_state_t state;
  logic [2:0] code;
  logic [7:0] char_out;

  modport enc (
    input ch, last_frame, is_framing, is_special, code_viol, disp_err,
    input ebuf_err, pll_unlock, type_b, bonded, lock_mark, state,
    output code, char_out
  );
  modport ctl (
    output ch, last_frame, is_framing, is_special, code_viol, disp_err,
    output ebuf_err, pll_unlock, type_b, bonded, lock_mark, state,
    input code, char_out
  );
endinterface

// ### rtl/bss_status_enc.sv
// Purpose: prioritised 3-bit character status and substitute character
// Assumes: flags describe the staged character of one channel
// Notes:   purely combinational
`timescale 1ns/1ps
`include "bss_defs.svh"
module bss_status_enc (
  // staged character and answer
  bss_enc_if.enc e
);
  import bss_pkg::*;

  // ----------------------------------------------------------------
  // decoder-level classification, highest priority first
  // ----------------------------------------------------------------
  logic [2:0] dec_code;
  logic [7:0] dec_char;
  always_comb
  begin
    dec_char = e.ch;
    if (e.code_viol)
    begin
      dec_code = `BSS_ST_VIOL; // RQ12
      dec_char = `BSS_CHAR_C07; // RQ12
    end
    else if (e.disp_err)
    begin
      dec_code = `BSS_ST_DISP; // RQ14
      // substitute tells what kind of character carried the error
      dec_char = e.is_framing ? `BSS_CHAR_C27 :
                 e.is_special ? `BSS_CHAR_C17 : `BSS_CHAR_C47; // RQ14
    end
    else if (e.is_framing)
      dec_code = `BSS_ST_FRAME; // RQ11
    else if (e.is_special)
      dec_code = `BSS_ST_SPECIAL; // RQ8
    else
      dec_code = `BSS_ST_DATA; // RQ7
  end

  // ----------------------------------------------------------------
  // state and buffer overrides
  // ----------------------------------------------------------------
  always_comb
  begin
    e.code = dec_code;
    e.char_out = dec_char;
    if (e.pll_unlock)
      e.code = `BSS_ST_LOSS; // RQ13 RQ16
    else if (!e.bonded)
    begin
      // independent channels: status straight from decoding
      if (e.ebuf_err)
        e.code = e.type_b ? `BSS_ST_LOSS : `BSS_ST_EBUF_LOCK; // RQ3
    end
    else
    begin
      case (e.state)
        st_no_sync, st_bond_failed:
          e.code = `BSS_ST_LOSS; // RQ5 RQ6 RQ13
        st_resync:
        begin
          e.char_out = e.last_frame; // RQ15
          if (e.lock_mark)
            e.code = `BSS_ST_EBUF_LOCK; // RQ10 RQ16
          else
            e.code = `BSS_ST_RESYNC; // RQ15
        end
        st_in_sync:
        begin
          if (e.ebuf_err)
            e.code = e.type_b ? `BSS_ST_LOSS : `BSS_ST_EBUF_LOCK; // RQ9 RQ13 RQ16
        end
        default:
          e.code = `BSS_ST_LOSS;
      endcase
    end
  end
endmodule // bss_status_enc

// ### dv/bss_rx_sync_props.sv
// Purpose: port assertions of the receive sync block
// Assumes: channel 0 watched, two-cycle character latency
// Notes: bound from the bench
`timescale 1ns/1ps
`include "bss_defs.svh"
module bss_rx_sync_props #(
  parameter int NCH = 4
) (
  input wire logic i_core_clk,
  input wire logic i_arst_n,
  input wire logic [NCH-1:0][7:0] i_dec_char,
  input wire logic [NCH-1:0] i_is_framing,
  input wire logic [NCH-1:0] i_is_special,
  input wire logic [NCH-1:0] i_code_viol,
  input wire logic [NCH-1:0] i_disp_err,
  input wire logic [NCH-1:0] i_pll_unlock,
  input wire logic [NCH-1:0][7:0] o_rx_data,
  input wire logic [NCH-1:0][2:0] o_rx_char_status
);
  logic [2:0] st;
  logic [7:0] dt;
  assign st = o_rx_char_status[0];
  assign dt = o_rx_data[0];
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_arst_n);
  sequence s_loss;
    ##2 st == `BSS_ST_LOSS;
  endsequence
  property p_unlock;
    i_pll_unlock[0] |-> s_loss;
  endproperty
  a_unlock: assert property (p_unlock) else $error("unlock not reported");
  property p_viol_char;
    st == `BSS_ST_VIOL |-> dt == `BSS_CHAR_C07 && $past(i_code_viol[0], 2);
  endproperty
  a_viol_char: assert property (p_viol_char) else $error("bad violation");
  property p_disp_char;
    st == `BSS_ST_DISP |-> dt inside {`BSS_CHAR_C17, `BSS_CHAR_C27, `BSS_CHAR_C47};
  endproperty
  a_disp_char: assert property (p_disp_char) else $error("bad disparity char");
  property p_disp_prio;
    st == `BSS_ST_DISP |-> $past(i_disp_err[0], 2) && !$past(i_code_viol[0], 2);
  endproperty
  a_disp_prio: assert property (p_disp_prio) else $error("bad disparity cause");
  property p_frame;
    st == `BSS_ST_FRAME |-> $past(i_is_framing[0], 2) && dt == $past(i_dec_char[0], 2);
  endproperty
  a_frame: assert property (p_frame) else $error("bad framing report");
  property p_data;
    st == `BSS_ST_DATA |-> dt == $past(i_dec_char[0], 2) && !$past(i_is_special[0], 2);
  endproperty
  a_data: assert property (p_data) else $error("bad data report");
  property p_special;
    st == `BSS_ST_SPECIAL |-> $past(i_is_special[0], 2) && !$past(i_is_framing[0], 2);
  endproperty
  a_special: assert property (p_special) else $error("bad special report");
  property p_clean;
    st inside {`BSS_ST_DATA, `BSS_ST_SPECIAL} |-> !$past(i_code_viol[0] | i_disp_err[0], 2);
  endproperty
  a_clean: assert property (p_clean) else $error("error char passed clean");
endmodule // bss_rx_sync_props

// ### dv/bss_host_model.sv
// Purpose: host logic capturing the parallel characters
// Assumes: character seen at the ports two edges after it is taken
// Notes: o_vld marks a capture that belongs to a driven character
`timescale 1ns/1ps
module bss_host_model #(
  parameter int NCH = 4
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_vld,
  input wire logic [NCH-1:0][7:0] i_data,
  input wire logic [NCH-1:0][2:0] i_status,
  output logic o_vld,
  output logic [NCH-1:0][7:0] o_data,
  output logic [NCH-1:0][2:0] o_status
);
  logic [1:0] pipe;
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      pipe <= 2'h0;
      o_vld <= 1'b0;
    end
    else
    begin
      pipe <= {pipe[0], i_vld};
      o_vld <= pipe[1];
    end
  end
  always_ff @(posedge i_clk)
  begin
    o_data <= i_data;
    o_status <= i_status;
  end
endmodule // bss_host_model

// ### dv/bss_rx_sync_tb.sv
// Purpose: self-checking bench of the receive sync block
// Assumes: all channels carry the same stream
// Notes: expected status queued by the driver, checked at the host
`timescale 1ns/1ps
`include "bss_defs.svh"
module bss_rx_sync_tb;
  localparam int NCH = 4;
  localparam logic [5:0] k_fr = 6'h01, k_sp = 6'h02, k_vi = 6'h04;
  localparam logic [5:0] k_di = 6'h08, k_eb = 6'h10, k_pl = 6'h20;
  localparam logic [7:0] fch = 8'hbc;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic vld = 1'b0;
  logic [5:0] fl = 6'h0;
  logic [NCH-1:0][7:0] dch = '0;
  logic [31:0] rdata;
  logic [NCH-1:0][7:0] rx_data, h_data;
  logic [NCH-1:0][2:0] rx_st, h_st;
  logic h_vld;
  logic [7:0] d;
  logic [11:0] notes[$];
  int errors = 0;
  int n_tests = 0;
  int cyc = 0;
  always #4 clk = ~clk;
  bss_rx_sync #(.NCH(NCH), .BOND_WIN(4)) i_dut (.i_core_clk(clk), .i_arst_n(rst_n),
    .i_reg_addr(addr), .i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd),
    .o_reg_rdata(rdata), .i_dec_char(dch), .i_is_framing({NCH{fl[0]}}),
    .i_is_special({NCH{fl[1]}}), .i_code_viol({NCH{fl[2]}}), .i_disp_err({NCH{fl[3]}}),
    .i_ebuf_err({NCH{fl[4]}}), .i_pll_unlock({NCH{fl[5]}}), .o_rx_data(rx_data),
    .o_rx_char_status(rx_st));
  bss_host_model #(.NCH(NCH)) i_host (.i_clk(clk), .i_rst_n(rst_n), .i_vld(vld),
    .i_data(rx_data), .i_status(rx_st), .o_vld(h_vld), .o_data(h_data), .o_status(h_st));
  // ----------------------------------------------------------------
  // checking
  // ----------------------------------------------------------------
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_tests++;
    if (s !== e)
    begin
      errors++;
      $display("BAD %s exp %h got %h", nm, e, s);
    end
  endtask
  task automatic chk_st(input logic [2:0] e, input logic [2:0] s);
    chk("status", {29'h0, e}, {29'h0, s});
  endtask
  task automatic chk_ch(input logic [7:0] e, input logic [7:0] s);
    chk("char", {24'h0, e}, {24'h0, s});
  endtask
  always @(negedge clk)
    if (h_vld)
    begin : mon
      logic [11:0] n;
      n = notes.pop_front();
      for (int c = 0; c < NCH; c++)
      begin
        chk_st(n[10:8], h_st[c]);
        if (n[11])
          chk_ch(n[7:0], h_data[c]);
      end
    end
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      errors++;
      print_verdict();
    end
  end
  // ----------------------------------------------------------------
  // drivers
  // ----------------------------------------------------------------
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic reg_rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk("register", e, rdata);
  endtask
  // ec[8] high: character not compared
  task automatic snd(input logic [7:0] c, input logic [5:0] f, input logic [2:0] es,
    input logic [8:0] ec);
    @(posedge clk);
    dch <= {NCH{c}};
    fl <= f;
    vld <= 1'b1;
    notes.push_back({~ec[8], es, ec[7:0]});
  endtask
  task automatic snd_d();
    d = 8'($urandom());
    snd(d, 6'h0, `BSS_ST_DATA, {1'b0, d});
  endtask
  task automatic quiet(input string nm);
    @(posedge clk);
    vld <= 1'b0;
    fl <= 6'h0;
    dch <= {NCH{8'h5a}};
    repeat (6) @(posedge clk);
    $display("test %s done", nm);
  endtask
  initial
  begin
    void'($urandom(32'hfb8f));
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    reg_rd(`BSS_OFS_CTRL, 32'h2);
    reg_rd(`BSS_OFS_STAT, 32'h0);
    reg_wr(8'h0c, 32'hffffffff);
    reg_rd(8'h0c, 32'h0);
    reg_rd(`BSS_OFS_CTRL, 32'h2);
    $display("test registers done");
    reg_wr(`BSS_OFS_CTRL, 32'h0);
    snd(fch, k_fr, `BSS_ST_FRAME, {1'b0, fch});
    snd_d();
    snd(8'h33, k_vi, `BSS_ST_VIOL, {1'b0, `BSS_CHAR_C07});
    snd(8'h44, k_eb, `BSS_ST_EBUF_LOCK, 9'h100);
    snd(8'h55, k_pl | k_vi, `BSS_ST_LOSS, 9'h100);
    quiet("bonding off");
    reg_wr(`BSS_OFS_CTRL, 32'h2);
    snd(fch, k_fr, `BSS_ST_LOSS, {1'b0, fch});
    snd(fch, k_fr, `BSS_ST_RESYNC, {1'b0, fch});
    snd_d();
    snd(8'h7c, k_sp, `BSS_ST_SPECIAL, 9'h07c);
    snd(fch, k_fr, `BSS_ST_FRAME, {1'b0, fch});
    snd(8'h12, k_vi | k_di, `BSS_ST_VIOL, {1'b0, `BSS_CHAR_C07});
    snd_d();
    snd(8'h21, k_di, `BSS_ST_DISP, {1'b0, `BSS_CHAR_C47});
    snd_d();
    snd(8'h7c, k_sp | k_di, `BSS_ST_DISP, {1'b0, `BSS_CHAR_C17});
    snd_d();
    snd(fch, k_fr | k_di, `BSS_ST_DISP, {1'b0, `BSS_CHAR_C27});
    snd_d();
    snd(8'h66, k_eb | k_di, `BSS_ST_EBUF_LOCK, 9'h100);
    snd_d();
    repeat (4) snd(8'h13, k_vi, `BSS_ST_VIOL, {1'b0, `BSS_CHAR_C07});
    snd(8'h14, 6'h0, `BSS_ST_LOSS, 9'h100);
    quiet("type a");
    reg_wr(`BSS_OFS_CTRL, 32'h3);
    snd(fch, k_fr, `BSS_ST_LOSS, {1'b0, fch});
    snd(fch, k_fr, `BSS_ST_EBUF_LOCK, {1'b0, fch});
    snd_d();
    snd(8'h7c, k_sp, `BSS_ST_SPECIAL, 9'h07c);
    quiet("type b");
    reg_rd(`BSS_OFS_LOCKCNT, 32'h2);
    reg_wr(`BSS_OFS_LOCKCNT, 32'h0);
    reg_rd(`BSS_OFS_LOCKCNT, 32'h0);
    reg_wr(`BSS_OFS_CTRL, 32'h7);
    reg_rd(`BSS_OFS_CTRL, 32'h3);
    reg_rd(`BSS_OFS_STAT, 32'h0);
    snd(8'h15, 6'h0, `BSS_ST_LOSS, 9'h100);
    quiet("forced resync");
    snd(fch, k_fr, `BSS_ST_LOSS, {1'b0, fch});
    repeat (6) snd(fch, k_fr, `BSS_ST_RESYNC, {1'b0, fch});
    snd(8'h16, 6'h0, `BSS_ST_LOSS, 9'h100);
    quiet("bond window");
    reg_rd(`BSS_OFS_STAT, 32'haa);
    print_verdict();
  end
endmodule // bss_rx_sync_tb
bind bss_rx_sync bss_rx_sync_props #(.NCH(NCH)) i_props (.*);
